// File: core/ckps_pkg.sv
// Contract
// - vga enable selects compared and switched source
// - vga keying only at 1:1, overlay needs capability
// - per-channel enables; all clear uses default select
// - reset clears enables, sets default select
// - compare after read mask and page
// - short components left-aligned, low bits zero
// - window switch or key selects palette graphics
// - match means low <= value <= high inclusive
// - key true shows overlay or vga pixel
// - overlay flag uses same inclusive bounds
package ckps_pkg;
  // register offsets
  localparam logic [3:0] ADDR_LOW_BASE = 4'h0;
  localparam logic [3:0] ADDR_HIGH_BASE = 4'h4;
  localparam logic [3:0] ADDR_KEY_CTRL = 4'h8;
  localparam logic [3:0] ADDR_MUX_CTRL2 = 4'h9;
  localparam logic [3:0] ADDR_READ_MASK = 4'hA;
  localparam logic [3:0] ADDR_PAGE = 4'hB;
  localparam logic [3:0] ADDR_DC_WIDTH = 4'hC;
  localparam logic [3:0] ADDR_STATUS = 4'hD;
  // channel numbering
  localparam int CH_RED = 0;
  localparam int CH_GREEN = 1;
  localparam int CH_BLUE = 2;
  localparam int CH_OVL = 3;
  localparam int NUM_CH = 4;
  // field positions
  localparam int KEY_DEF_BIT = 4;
  localparam int MUX_VGA_EN_BIT = 7;
  localparam int MUX_RATIO_ONE_BIT = 0;
  localparam int MUX_OVL_CAP_BIT = 1;
  localparam int STAT_KEY_BIT = 4;
  localparam int STAT_SEL_BIT = 5;
  // values after reset
  localparam logic [3:0] KEY_EN_RST = 4'h0;
  localparam logic KEY_DEF_RST = 1'b1;
  localparam logic [7:0] LOW_RST = 8'h00;
  localparam logic [7:0] HIGH_RST = 8'hFF;
  localparam logic [7:0] READ_MASK_RST = 8'hFF;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [3:0] DC_WIDTH_RST = 4'h8;
  localparam logic [3:0] DC_WIDTH_FULL = 4'h8;
endpackage

// File: core/ckps_range_cmp.sv
`timescale 1ns/1ns
module ckps_range_cmp #(
  parameter int W = 8
) (
  input wire logic [W-1:0] value_i,
  input wire logic [W-1:0] low_i,
  input wire logic [W-1:0] high_i,
  output logic match_o
);
  if (W < 1)
  begin : g_bad_width
    $error("ckps_range_cmp: width must be at least one");
  end

  assign match_o = (low_i <= value_i) && (value_i <= high_i);
endmodule // ckps_range_cmp

// File: core/ckps_color_key.sv
`timescale 1ns/1ns
module ckps_color_key #(
  parameter int COMP_W = 8
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  output logic [7:0] rdata_o,
  input wire logic pix_valid_i,
  input wire logic [7:0] dc_red_i,
  input wire logic [7:0] dc_green_i,
  input wire logic [7:0] dc_blue_i,
  input wire logic [7:0] ovl_pix_i,
  input wire logic [7:0] vga_pix_i,
  input wire logic win_switch_i,
  output logic pix_valid_o,
  output logic [23:0] dc_pix_o,
  output logic [7:0] gfx_index_o,
  output logic gfx_sel_o
);
  if (COMP_W != 8)
  begin : g_bad_comp
    $error("ckps_color_key: comparisons are fixed at eight bits");
  end

  typedef struct packed {
    logic [3:0][7:0] low;
    logic [3:0][7:0] high;
    logic [3:0] key_en;
    logic key_def;
    logic vga_en;
    logic ratio_one;
    logic ovl_cap;
    logic [7:0] read_mask;
    logic [7:0] page;
    logic [3:0] dc_width;
    logic [7:0] rdata;
    logic vld;
    logic [23:0] dc_pix;
    logic [7:0] gfx_idx;
    logic gfx_sel;
    logic [3:0] match;
    logic key;
  } ckps_state_type;

  localparam ckps_state_type ST_RESET = '{
    low: {4{ckps_pkg::LOW_RST}},
    high: {4{ckps_pkg::HIGH_RST}},
    key_en: ckps_pkg::KEY_EN_RST,
    key_def: ckps_pkg::KEY_DEF_RST,
    vga_en: 1'b0,
    ratio_one: 1'b1,
    ovl_cap: 1'b1,
    read_mask: ckps_pkg::READ_MASK_RST,
    page: ckps_pkg::PAGE_RST,
    dc_width: ckps_pkg::DC_WIDTH_RST,
    rdata: 8'h00,
    vld: 1'b0,
    dc_pix: 24'h0000_00,
    gfx_idx: 8'h00,
    gfx_sel: 1'b0,
    match: 4'h0,
    key: 1'b0
  };

  logic [1:0] rst_sync;
  logic rst_n;
  ckps_state_type st;
  ckps_state_type next_st;
  logic [2:0] shift;
  logic [7:0] al_red;
  logic [7:0] al_green;
  logic [7:0] al_blue;
  logic [7:0] gfx_proc;
  logic [3:0][7:0] cmp_val;
  logic [3:0] ch_match;
  logic key_ok_mode;
  logic key_now;
  logic sel_now;

  // reset release through two flops
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign shift = (st.dc_width == 4'h0 || st.dc_width > ckps_pkg::DC_WIDTH_FULL)
    ? 3'h0 : 3'(ckps_pkg::DC_WIDTH_FULL - st.dc_width);
  assign al_red = dc_red_i << shift;
  assign al_green = dc_green_i << shift;
  assign al_blue = dc_blue_i << shift;

  // vga or overlay as key source
  assign gfx_proc = ((st.vga_en ? vga_pix_i : ovl_pix_i) & st.read_mask)
    | (st.page & ~st.read_mask);

  assign cmp_val[ckps_pkg::CH_RED] = al_red;
  assign cmp_val[ckps_pkg::CH_GREEN] = al_green;
  assign cmp_val[ckps_pkg::CH_BLUE] = al_blue;
  assign cmp_val[ckps_pkg::CH_OVL] = gfx_proc;

  for (genvar c = 0; c < ckps_pkg::NUM_CH; c++)
  begin : g_ch
    ckps_range_cmp #(
      .W(COMP_W)
    ) u_cmp (
      .value_i(cmp_val[c]),
      .low_i(st.low[c]),
      .high_i(st.high[c]),
      .match_o(ch_match[c])
    );
    a_ch_bounds: assert property (
      @(posedge mclk_i) disable iff (!rst_n)
      cmp_val[c] < st.low[c] || cmp_val[c] > st.high[c] |-> !ch_match[c])
      else $error("channel matched outside its bounds");
  end

  assign key_ok_mode = st.vga_en ? st.ratio_one : st.ovl_cap;

  always_comb
  begin
    if (!key_ok_mode)
    begin
      key_now = 1'b0;
    end
    else if (st.key_en == 4'h0)
    begin
      key_now = st.key_def;
    end
    else
    begin
      key_now = &(ch_match | ~st.key_en);
    end
  end

  assign sel_now = win_switch_i | key_now;

  always_comb
  begin
    next_st = st;
    next_st.vld = pix_valid_i;
    if (pix_valid_i)
    begin
      next_st.gfx_sel = sel_now;
      next_st.gfx_idx = gfx_proc;
      next_st.dc_pix = {al_red, al_green, al_blue};
      next_st.match = ch_match;
      next_st.key = key_now;
    end
    if (wr_stb_i)
    begin
      unique case (addr_i)
        4'h0, 4'h1, 4'h2, 4'h3:
        begin
          next_st.low[addr_i[1:0]] = wdata_i;
        end
        4'h4, 4'h5, 4'h6, 4'h7:
        begin
          next_st.high[addr_i[1:0]] = wdata_i;
        end
        ckps_pkg::ADDR_KEY_CTRL:
        begin
          next_st.key_en = wdata_i[3:0];
          next_st.key_def = wdata_i[ckps_pkg::KEY_DEF_BIT];
        end
        ckps_pkg::ADDR_MUX_CTRL2:
        begin
          next_st.vga_en = wdata_i[ckps_pkg::MUX_VGA_EN_BIT];
          next_st.ratio_one = wdata_i[ckps_pkg::MUX_RATIO_ONE_BIT];
          next_st.ovl_cap = wdata_i[ckps_pkg::MUX_OVL_CAP_BIT];
        end
        ckps_pkg::ADDR_READ_MASK:
        begin
          next_st.read_mask = wdata_i;
        end
        ckps_pkg::ADDR_PAGE:
        begin
          next_st.page = wdata_i;
        end
        ckps_pkg::ADDR_DC_WIDTH:
        begin
          next_st.dc_width = wdata_i[3:0];
        end
        default:
        begin
        end
      endcase
    end
    next_st.rdata = 8'h00;
    if (rd_stb_i)
    begin
      unique case (addr_i)
        4'h0, 4'h1, 4'h2, 4'h3:
        begin
          next_st.rdata = st.low[addr_i[1:0]];
        end
        4'h4, 4'h5, 4'h6, 4'h7:
        begin
          next_st.rdata = st.high[addr_i[1:0]];
        end
        ckps_pkg::ADDR_KEY_CTRL:
        begin
          next_st.rdata = {3'h0, st.key_def, st.key_en};
        end
        ckps_pkg::ADDR_MUX_CTRL2:
        begin
          next_st.rdata = {st.vga_en, 5'h00, st.ovl_cap, st.ratio_one};
        end
        ckps_pkg::ADDR_READ_MASK:
        begin
          next_st.rdata = st.read_mask;
        end
        ckps_pkg::ADDR_PAGE:
        begin
          next_st.rdata = st.page;
        end
        ckps_pkg::ADDR_DC_WIDTH:
        begin
          next_st.rdata = {4'h0, st.dc_width};
        end
        ckps_pkg::ADDR_STATUS:
        begin
          next_st.rdata = {2'h0, st.gfx_sel, st.key, st.match};
        end
        default:
        begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= ST_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign pix_valid_o = st.vld;
  assign dc_pix_o = st.dc_pix;
  assign gfx_index_o = st.gfx_idx;
  assign gfx_sel_o = st.gfx_sel;

  sequence s_pix_cfg_all_off;
    pix_valid_i && !win_switch_i && st.key_en == 4'h0 && key_ok_mode;
  endsequence

  sequence s_red_only_in_range;
    pix_valid_i && key_ok_mode && st.key_en == 4'h1
      && st.low[ckps_pkg::CH_RED] <= al_red
      && al_red <= st.high[ckps_pkg::CH_RED];
  endsequence

  a_reset_key_defaults: assert property (
    @(posedge mclk_i) $rose(rst_n) |-> st.key_en == 4'h0 && st.key_def)
    else $error("key control not at reset defaults");
  a_window_forces_gfx: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    pix_valid_i && win_switch_i |=> gfx_sel_o && pix_valid_o)
    else $error("window switch did not select graphics");
  a_default_select_used: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    s_pix_cfg_all_off |=> gfx_sel_o == $past(st.key_def))
    else $error("default select not followed");
  a_red_match_keys: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    s_red_only_in_range |=> gfx_sel_o)
    else $error("in-range red did not key");
  a_red_out_blocks: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    pix_valid_i && !win_switch_i && st.key_en == 4'h1
      && al_red > st.high[ckps_pkg::CH_RED] |=> !gfx_sel_o)
    else $error("out-of-range red keyed");
  a_vga_ratio_gate: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    pix_valid_i && !win_switch_i && st.vga_en && !st.ratio_one
      |=> !gfx_sel_o)
    else $error("vga keyed outside 1:1 ratio");
  a_source_select: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    pix_valid_i && st.read_mask == 8'hFF
      |=> gfx_index_o == ($past(st.vga_en) ? $past(vga_pix_i)
                                           : $past(ovl_pix_i)))
    else $error("wrong graphics source");
  a_mask_page_merge: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    pix_valid_i && st.read_mask == 8'h00 |=> gfx_index_o == $past(st.page))
    else $error("page not merged under mask");
  a_left_align_zero: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    pix_valid_i && st.dc_width == 4'h4 |=> dc_pix_o[3:0] == 4'h0
      && dc_pix_o[11:8] == 4'h0 && dc_pix_o[19:16] == 4'h0)
    else $error("low bits not zero-filled");
  a_ovl_flag_match: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    pix_valid_i && !win_switch_i && !st.vga_en && st.ovl_cap
      && st.key_en == 4'h8 && gfx_proc >= st.low[ckps_pkg::CH_OVL]
      && gfx_proc <= st.high[ckps_pkg::CH_OVL] |=> gfx_sel_o)
    else $error("overlay flag did not key");
  a_key_shows_gfx: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    pix_valid_i && key_now |=> gfx_sel_o)
    else $error("keyed pixel did not show graphics");
  a_read_latency: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    rd_stb_i && addr_i == ckps_pkg::ADDR_KEY_CTRL
      |=> rdata_o == {3'h0, $past(st.key_def), $past(st.key_en)})
    else $error("key control read wrong");
endmodule // ckps_color_key

// File: tb/ckps_gfx_source.sv
`timescale 1ns/1ns
module ckps_gfx_source (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic send_i,
  input wire logic [40:0] pix_i,
  output logic valid_o,
  output logic [40:0] pix_o
);
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      valid_o <= 1'b0;
      pix_o <= '0;
    end
    else
    begin
      valid_o <= send_i;
      // idle bus toggles, so the last pixel returns every second idle cycle
      pix_o <= send_i ? pix_i : ~pix_o;
    end
  end
endmodule // ckps_gfx_source

// File: tb/ckps_color_key_bench.sv
`timescale 1ns/1ns
module ckps_color_key_bench;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic send = 1'b0;
  logic [40:0] req = '0;
  logic pv;
  logic [40:0] px;
  logic [7:0] rdata;
  logic pvo;
  logic [23:0] dco;
  logic [7:0] gix;
  logic sel;
  logic [7:0] d;
  logic [7:0] rv [4] = '{8'h0F, 8'h10, 8'h20, 8'h21};
  logic ev [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;

  ckps_gfx_source i_ckps_gfx_source (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .send_i(send), .pix_i(req), .valid_o(pv), .pix_o(px));

  ckps_color_key i_ckps_color_key (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .addr_i(addr),
    .wdata_i(wdata),
    .wr_stb_i(wr_stb),
    .rd_stb_i(rd_stb),
    .rdata_o(rdata),
    .pix_valid_i(pv),
    .dc_red_i(px[40:33]),
    .dc_green_i(px[32:25]),
    .dc_blue_i(px[24:17]),
    .ovl_pix_i(px[16:9]),
    .vga_pix_i(px[8:1]),
    .win_switch_i(px[0]),
    .pix_valid_o(pvo),
    .dc_pix_o(dco),
    .gfx_index_o(gix),
    .gfx_sel_o(sel)
  );

  initial
  begin
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge mclk_i);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk_i);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk_i);
    rd_stb <= 1'b0;
    @(negedge mclk_i);
    v = rdata;
  endtask

  function automatic logic [40:0] mk(input logic [7:0] r, input logic [7:0] g,
    input logic [7:0] o, input logic [7:0] v, input logic w);
    return {r, g, 8'h00, o, v, w};
  endfunction

  // one pixel through the controller model, result settled on return
  task automatic pix(input logic [40:0] p);
    @(posedge mclk_i);
    req <= p;
    send <= 1'b1;
    @(posedge mclk_i);
    send <= 1'b0;
    @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  initial
  begin
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rd(4'h8, d);
    chk(d, 8'h10);
    @(negedge mclk_i);
    chk(rdata, 8'h00);
    pix(mk(8'h12, 8'h00, 8'h00, 8'h00, 1'b0));
    chk(sel, 1'b1);
    chk(pvo, 1'b1);
    wr(4'hE, 8'h00);
    rd(4'h8, d);
    chk(d, 8'h10);
    wr(4'h8, 8'h00);
    pix(mk(8'h12, 8'h00, 8'h00, 8'h00, 1'b0));
    chk(sel, 1'b0);
    pix(mk(8'h12, 8'h00, 8'h00, 8'h00, 1'b1));
    chk(sel, 1'b1);
    wr(4'h0, 8'h10);
    wr(4'h4, 8'h20);
    wr(4'h8, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      pix(mk(rv[i], 8'h00, 8'h00, 8'h00, 1'b0));
      chk(sel, ev[i]);
    end
    wr(4'h1, 8'h30);
    wr(4'h5, 8'h30);
    wr(4'h8, 8'h03);
    pix(mk(8'h15, 8'h30, 8'h00, 8'h00, 1'b0));
    chk(sel, 1'b1);
    pix(mk(8'h15, 8'h31, 8'h00, 8'h00, 1'b0));
    chk(sel, 1'b0);
    rd(4'hD, d);
    chk(d, 8'h0D);
    pix(mk(8'h15, 8'h31, 8'h00, 8'h00, 1'b1));
    chk(sel, 1'b1);
    wr(4'h8, 8'h08);
    wr(4'h3, 8'h40);
    wr(4'h7, 8'h40);
    pix(mk(8'h00, 8'h00, 8'h40, 8'h00, 1'b0));
    chk({sel, gix}, 9'h140);
    pix(mk(8'h00, 8'h00, 8'h41, 8'h00, 1'b0));
    chk(sel, 1'b0);
    wr(4'h9, 8'h83);
    pix(mk(8'h00, 8'h00, 8'h41, 8'h40, 1'b0));
    chk({sel, gix}, 9'h140);
    pix(mk(8'h00, 8'h00, 8'h40, 8'h41, 1'b0));
    chk({sel, gix}, 9'h041);
    wr(4'h9, 8'h82);
    pix(mk(8'h00, 8'h00, 8'h00, 8'h40, 1'b0));
    chk(sel, 1'b0);
    wr(4'h9, 8'h01);
    pix(mk(8'h00, 8'h00, 8'h40, 8'h00, 1'b0));
    chk(sel, 1'b0);
    wr(4'h9, 8'h03);
    wr(4'hA, 8'h0F);
    wr(4'hB, 8'h30);
    wr(4'h3, 8'h35);
    wr(4'h7, 8'h35);
    pix(mk(8'h00, 8'h00, 8'hA5, 8'h00, 1'b0));
    chk({sel, gix}, 9'h135);
    wr(4'hA, 8'h00);
    pix(mk(8'h00, 8'h00, 8'hA5, 8'h00, 1'b0));
    chk(gix, 8'h30);
    wr(4'hC, 8'h04);
    wr(4'h0, 8'hA0);
    wr(4'h4, 8'hA0);
    wr(4'h8, 8'h01);
    pix(mk(8'h0A, 8'h05, 8'h00, 8'h00, 1'b0));
    chk(sel, 1'b1);
    chk(dco, 24'hA0_5000);
    // second reset in mid-run must restore the defaults
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rd(4'h8, d);
    chk(d, 8'h10);
    rd(4'hC, d);
    chk(d, 8'h08);
    pix(mk(8'h0A, 8'h00, 8'h00, 8'h00, 1'b0));
    chk(sel, 1'b1);
    chk(dco, 24'h0A_0000);
    summarize();
  end
endmodule // ckps_color_key_bench
